// ==== logic/sink_driver_params.svh ====
`ifndef SINK_DRIVER_PARAMS_SVH
`define SINK_DRIVER_PARAMS_SVH

// number of driver channels
`define NUM_CHANNELS 8
// system clock period in ns (250 MHz)
`define CLOCK_PERIOD_NS 4
// least pulse width of the flop clock and clear, in ns
`define MIN_PULSE_NS 30
// least pulse width in system cycles, rounded up
`define MIN_PULSE_CYC \
    ((`MIN_PULSE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
// highest flop clock rate in MHz, and its least period in ns
`define MAX_FLOP_CLK_MHZ 20
`define MIN_FLOP_PERIOD_NS (1000 / `MAX_FLOP_CLK_MHZ)
// least flop clock period in system cycles, rounded up
`define MIN_FLOP_PERIOD_CYC \
    ((`MIN_FLOP_PERIOD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
// width of the pulse and period counters
`define CNT_W 4
// value of the stored bits after a clear
`define STORE_CLEAR_VAL 8'h00

`endif

// ==== logic/sink_driver_pkg.sv ====
package sink_driver_pkg;

    // level phase of the sampled flop clock, one-hot
    typedef enum logic [1:0]
    {
        PH_LOW = 2'b01,
        PH_HIGH = 2'b10
    } clk_phase_t;

endpackage

// ==== logic/sink_channel.sv ====
`timescale 1ns/1ns
`include "sink_driver_params.svh"

// one storage flop of a driver channel
module sink_channel
    import sink_driver_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear_n,
    input wire logic capture,
    input wire logic data_in,
    output logic stored_q
);

    // next stored value
    logic stored_d;

    // clear beats capture, capture beats hold
    assign stored_d = !clear_n ? 1'b0 : (capture ? data_in : stored_q);

    // storage flop, async system reset to the released state
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stored_q <= 1'b0;
        end
        else
        begin
            stored_q <= stored_d;
        end
    end

endmodule

// ==== logic/octal_latched_sink_driver.sv ====
`timescale 1ns/1ns
`include "sink_driver_params.svh"

// What this block does
// - eight channels, one flop each, shared clock/clear
// - clear low releases all sinks at once
// - rising flop clock stores data; high sinks
// - no rising edge keeps prior output level
module octal_latched_sink_driver
    import sink_driver_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic FLOP_RESET_N,
    input wire logic FLOP_CLK,
    input wire logic [7:0] CHANNEL_DATA_IN,
    input wire logic [7:0] SINK_OUTPUT_N_I,
    output logic [7:0] SINK_OUTPUT_N_O,
    output logic [7:0] SINK_OUTPUT_N_OE,
    output logic WIDTH_VIOLATION,
    output logic RATE_VIOLATION
);

    // counter limits at counter width
    localparam logic [`CNT_W-1:0] PULSE_MIN = `CNT_W'(`MIN_PULSE_CYC);
    localparam logic [`CNT_W-1:0] PERIOD_MIN =
        `CNT_W'(`MIN_FLOP_PERIOD_CYC);
    localparam logic [`CNT_W-1:0] CNT_TOP = {`CNT_W{1'b1}};

    // saturating increment, used by all three counters
    function automatic logic [`CNT_W-1:0] sat_inc
    (
        input logic [`CNT_W-1:0] v
    );
        sat_inc = (v == CNT_TOP) ? v : v + `CNT_W'(1);
    endfunction

    // previous sample of the flop clock pin
    logic flop_clk_q;
    // phase tracker of the flop clock
    clk_phase_t phase_q;
    clk_phase_t phase_d;
    // cycles spent in the current flop clock level
    logic [`CNT_W-1:0] level_cnt_q;
    logic [`CNT_W-1:0] level_cnt_d;
    // cycles since the last rising flop clock edge
    logic [`CNT_W-1:0] period_cnt_q;
    logic [`CNT_W-1:0] period_cnt_d;
    // a rising edge has been seen, so the period count is meaningful
    logic seen_rise_q;
    // cycles the clear has been low
    logic [`CNT_W-1:0] clr_cnt_q;
    logic [`CNT_W-1:0] clr_cnt_d;
    logic flop_reset_n_q;
    // registered violation flags
    logic width_viol_q;
    logic rate_viol_q;
    // stored channel bits
    logic [`NUM_CHANNELS-1:0] state_q;

    // decoded edges of the sampled pins
    wire rise_w = FLOP_CLK && !flop_clk_q;
    wire fall_w = !FLOP_CLK && flop_clk_q;
    wire clr_release_w = FLOP_RESET_N && !flop_reset_n_q;
    // a capture needs the clear released in the same cycle
    wire capture_w = rise_w && FLOP_RESET_N;
    // a level that ended before the least width
    wire clk_short_w = (rise_w || fall_w) && (level_cnt_q < PULSE_MIN);
    wire clr_short_w = clr_release_w && (clr_cnt_q < PULSE_MIN);
    // two rising edges closer than the least period
    wire rate_w = rise_w && seen_rise_q && (period_cnt_q < PERIOD_MIN);

    // eight identical channels on one clock and one clear
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CHANNELS; ch++)
        begin : g_chan
            sink_channel u_chan
            (
                .clk(CLOCK),
                .rst_b(RST_B),
                .clear_n(FLOP_RESET_N),
                .capture(capture_w),
                .data_in(CHANNEL_DATA_IN[ch]),
                .stored_q(state_q[ch])
            );
        end
    endgenerate

    // open drain: the pin is only ever pulled low
    assign SINK_OUTPUT_N_O = 8'h00;
    // clear gates the sinks at once, not one cycle late
    assign SINK_OUTPUT_N_OE = state_q & {8{FLOP_RESET_N}};
    assign WIDTH_VIOLATION = width_viol_q;
    assign RATE_VIOLATION = rate_viol_q;

    // phase tracker follows the sampled pin
    always_comb
    begin
        phase_d = phase_q;
        case (phase_q)
            PH_LOW:
            begin
                // only a rise leaves low
                if (rise_w)
                begin
                    phase_d = PH_HIGH;
                end
            end
            PH_HIGH:
            begin
                // a fall goes back without any capture
                if (fall_w)
                begin
                    phase_d = PH_LOW;
                end
            end
            default:
            begin
                phase_d = PH_LOW;
            end
        endcase
    end

    // level count restarts on every level change, period count on a rise, clear count while released
    assign level_cnt_d = (rise_w || fall_w) ? `CNT_W'(1)
                                            : sat_inc(level_cnt_q);
    assign period_cnt_d = rise_w ? `CNT_W'(1) : sat_inc(period_cnt_q);
    assign clr_cnt_d = FLOP_RESET_N ? `CNT_W'(0) : sat_inc(clr_cnt_q);

    // pin history and phase
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            flop_clk_q <= 1'b0;
            flop_reset_n_q <= 1'b1;
            phase_q <= PH_LOW;
        end
        else
        begin
            flop_clk_q <= FLOP_CLK;
            flop_reset_n_q <= FLOP_RESET_N;
            phase_q <= phase_d;
        end
    end

    // counters; a saturated count simply means long enough
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            level_cnt_q <= CNT_TOP;
            period_cnt_q <= CNT_TOP;
            clr_cnt_q <= `CNT_W'(0);
            seen_rise_q <= 1'b0;
        end
        else
        begin
            level_cnt_q <= level_cnt_d;
            period_cnt_q <= period_cnt_d;
            clr_cnt_q <= clr_cnt_d;
            seen_rise_q <= seen_rise_q || rise_w;
        end
    end

    // violation pulses only report; the capture still happens,
    // because a real part would not refuse a short pulse either
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            width_viol_q <= 1'b0;
            rate_viol_q <= 1'b0;
        end
        else
        begin
            width_viol_q <= clk_short_w || clr_short_w;
            rate_viol_q <= rate_w;
        end
    end

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);

    // clear low releases every sink in the same cycle
    a_clear_releases_all: assert property
        (!FLOP_RESET_N |-> (SINK_OUTPUT_N_OE == 8'h00))
        else $error("sink on while clear low");

    // clear held two cycles leaves nothing stored
    a_clear_empties_store: assert property
        (!FLOP_RESET_N [*2] |-> (state_q == `STORE_CLEAR_VAL))
        else $error("store not cleared");

    // a rising edge stores all eight data bits
    a_capture_on_rise: assert property
        (capture_w |=> (state_q == $past(CHANNEL_DATA_IN)))
        else $error("data not captured on rise");

    // stored high sinks, stored low releases
    a_sink_polarity: assert property
        (capture_w ##1 FLOP_RESET_N |->
            (SINK_OUTPUT_N_OE == $past(CHANNEL_DATA_IN)))
        else $error("sink level wrong after capture");

    // without a rise the outputs keep their level
    a_hold_no_rise: assert property
        ((FLOP_RESET_N && !rise_w) ##1 FLOP_RESET_N |->
            $stable(SINK_OUTPUT_N_OE))
        else $error("output changed without rise");

    // a falling edge never loads data
    a_fall_keeps_level: assert property
        ((fall_w && FLOP_RESET_N) |=> (state_q == $past(state_q)))
        else $error("fall changed stored level");

    // phase follows the pin one cycle later
    a_phase_tracks_pin: assert property
        (##1 (phase_q == (flop_clk_q ? PH_HIGH : PH_LOW)))
        else $error("phase lost the flop clock");

    // short high pulse is flagged on the next cycle
    a_short_pulse_flag: assert property
        ((FLOP_CLK && !flop_clk_q) ##1 !FLOP_CLK |=> WIDTH_VIOLATION)
        else $error("short pulse not flagged");

endmodule

// ==== bench/host_ctrl_model.sv ====
`timescale 1ns/1ns
// controller side: drives data, flop clock, clear; pulls the pins up
module host_ctrl_model
(
    input wire logic clk,
    input wire logic [7:0] sink_o,
    input wire logic [7:0] sink_oe,
    output logic flop_reset_n,
    output logic flop_clk,
    output logic [7:0] data,
    output logic [7:0] pin
);
    // open-drain wire with pull-up: released bits read high
    assign pin = (sink_oe & sink_o) | ~sink_oe;

    initial
    begin
        flop_reset_n = 1'b1;
        flop_clk = 1'b0;
        data = 8'h00;
    end

    // one capture, data and clear settled a cycle ahead
    task automatic capture(input logic [7:0] d, input int hi, input int lo);
        @(negedge clk);
        data = d;
        flop_reset_n = 1'b1;
        @(negedge clk);
        flop_clk = 1'b1;
        repeat (hi) @(negedge clk);
        // hold over: data is junk from here, so flip it
        data = ~d;
        flop_clk = 1'b0;
        repeat (lo) @(negedge clk);
    endtask

    // clear pulse with a stray rise inside, which must not load
    task automatic clear(input int cyc);
        @(negedge clk);
        flop_reset_n = 1'b0;
        data = 8'hFF;
        repeat (2) @(negedge clk);
        flop_clk = 1'b1;
        repeat (cyc) @(negedge clk);
        flop_clk = 1'b0;
        flop_reset_n = 1'b1;
    endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    logic clock;
    logic rst_b;
    wire logic flop_reset_n;
    wire logic flop_clk;
    wire logic [7:0] data;
    wire logic [7:0] pin;
    wire logic [7:0] sink_o;
    wire logic [7:0] sink_oe;
    wire logic width_viol;
    wire logic rate_viol;
    logic [7:0] exp_q[$]; // expected pin levels, oldest first
    logic [7:0] d;
    int err_total = 0;
    int check_count = 0;
    int wid_seen = 0;
    int rate_seen = 0;
    int seed;

    octal_latched_sink_driver i_octal_latched_sink_driver (
        .CLOCK(clock), .RST_B(rst_b), .FLOP_RESET_N(flop_reset_n),
        .FLOP_CLK(flop_clk), .CHANNEL_DATA_IN(data),
        .SINK_OUTPUT_N_I(pin), .SINK_OUTPUT_N_O(sink_o),
        .SINK_OUTPUT_N_OE(sink_oe), .WIDTH_VIOLATION(width_viol),
        .RATE_VIOLATION(rate_viol));

    host_ctrl_model i_host_ctrl_model (
        .clk(clock), .sink_o(sink_o), .sink_oe(sink_oe),
        .flop_reset_n(flop_reset_n), .flop_clk(flop_clk), .data(data),
        .pin(pin));

    // 250 MHz
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // scoreboard: oldest note against the settled pins
    always @(posedge clock)
    begin
        #1;
        if (exp_q.size() > 0)
            check("sink pins", pin, exp_q.pop_front());
        if (width_viol === 1'b1)
            wid_seen++;
        if (rate_viol === 1'b1)
            rate_seen++;
    end

    // hang guard
    initial
    begin
        repeat (5000) @(posedge clock);
        err_total++;
        $display("mismatch run time limit");
        complete_run();
    end

    initial
    begin
        seed = 32'h709A1AB7;
        rst_b = 1'b0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        exp_q.push_back(8'hFF);
        repeat (10) @(negedge clock);
        // walking one: each channel alone
        for (int ch = 0; ch < 8; ch++)
        begin
            i_host_ctrl_model.capture(8'h01 << ch, 8, 8);
            exp_q.push_back(~(8'h01 << ch));
        end
        // all-on, all-off, then random patterns
        for (int i = 0; i < 10; i++)
        begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
            i_host_ctrl_model.capture(d, 8, 8);
            exp_q.push_back(~d);
        end
        check("legal flags", 8'(wid_seen + rate_seen), 8'h00);
        $display("test captures done");
        i_host_ctrl_model.clear(8);
        exp_q.push_back(8'hFF);
        repeat (3) @(negedge clock);
        $display("test clear done");
        // short, fast pulses still load but get flagged
        i_host_ctrl_model.capture(8'h5A, 3, 3);
        i_host_ctrl_model.capture(8'hC3, 3, 3);
        exp_q.push_back(~8'hC3);
        // one-cycle high pulse: loads, and is flagged right after its fall
        i_host_ctrl_model.capture(8'h96, 1, 3);
        exp_q.push_back(~8'h96);
        repeat (4) @(negedge clock);
        check("width flag", 8'(wid_seen > 0), 8'h01);
        check("rate flag", 8'(rate_seen > 0), 8'h01);
        $display("test short pulses done");
        complete_run();
    end
endmodule
